/* File: verilog/tpl_link.sv */
// timer channel pair linking control, register port and pair output logic
// Contract
// - bit 24 combines channels six and seven
// - protected fields writable only with protection disabled
// - bit 23 reserved, always reads zero
// - bit 22 enables fault control pair four
// - bit 21 enables value sync pair four
// - bit 20 enables deadtime pair four
// - bit 19 arms dual edge capture pair four
// - arm ignored unless dual edge mode set
// - one-shot clears arm after upper capture
// - bit 18 enables dual edge mode pair four
// - complement inverts upper output, else equal
// - same fields for pairs 0,2,4,6
`timescale 1ns/100ps
module tpl_link
(
   input  wire logic                   clk_in,            // 10 MHz clock
   input  wire logic                   resetn_in,         // async reset, active low
   input  wire tpl_pkg::tpl_bus_t      bus_in,            // register request
   input  wire logic [3:0]             lower_pwm_in,      // lower channel pwm per pair
   input  wire logic [3:0]             lower_evt_in,      // lower channel capture event
   input  wire logic [3:0]             upper_evt_in,      // upper channel capture event
   input  wire logic [3:0]             one_shot_in,       // one-shot capture selected
   output logic [31:0]                 rdata_out,         // read data, cycle after strobe
   output logic [3:0]                  lower_out_out,     // lower channel output
   output logic [3:0]                  upper_out_out,     // upper channel output
   output logic [3:0]                  combined_out,      // pair combined
   output logic [3:0]                  fault_en_out,      // fault control enable
   output logic [3:0]                  sync_en_out,       // value sync enable
   output logic [3:0]                  deadtime_en_out,   // deadtime enable
   output logic [3:0]                  dual_mode_out,     // dual edge mode enable
   output logic [3:0]                  capture_out        // one-cycle capture pulse
);
   import tpl_pkg::*;

   // register state; the mode register is a single flop since only
   // write_protect_disable lives there in this block
   logic [31:0]    link_ff;      // channel_pair_link_config storage
   logic [31:0]    nxt_link;     // next value of the link register
   logic           wpd_ff;       // write_protect_disable
   logic [3:0]     cap_done_ff;  // upper capture taken (sticky status)
   tpl_cap_t       cap_st_ff [NUM_PAIRS];  // capture sequence per pair
   logic [3:0]     upper_hit;    // upper capture taken this cycle

   // slice of pair p from a register word
   function automatic logic [7:0] pair_slice(input logic [31:0] w, input int p);
      pair_slice = w[p*PAIR_W +: PAIR_W];
   endfunction : pair_slice

   // bus write to link register with protection masking
   // the loop repeats the same slice logic for every pair
   always_comb
   begin
      nxt_link = link_ff;
      // default: every field holds unless a write or a hardware clear touches it
      for (int p = 0; p < NUM_PAIRS; p++)
      begin
         logic [7:0] cur;
         logic [7:0] wr;
         logic [7:0] keep;
         cur  = pair_slice(link_ff, p);
         wr   = pair_slice(bus_in.wdata, p);
         // while protection is active the protected bits keep their old value
         keep = wpd_ff ? 8'h00 : PROT_MASK;
         // a link write replaces only the bits that are not kept
         if (bus_in.wr && bus_in.addr == ADDR_LINK_CFG)
         begin
            cur = (cur & keep) | (wr & ~keep);
         end
         // hardware clear of the arm wins over a same-cycle write: the capture is done
         if (upper_hit[p] && one_shot_in[p])
         begin
            cur[F_DEARM] = 1'b0;
         end
         // the reserved bit is forced low so no write can ever set it
         cur = cur & ~RSVD_MASK;
         nxt_link[p*PAIR_W +: PAIR_W] = cur;
      end
   end

   // link register storage
   // one flop word holds all four pair slices
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         link_ff <= LINK_RESET;
      else
         link_ff <= nxt_link;
   end

   // mode register holding the protection disable
   // protection is active after reset, so a stray write cannot reconfigure a running pair
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         wpd_ff <= 1'b0;
      else if (bus_in.wr && bus_in.addr == ADDR_MODE_CTRL)
         wpd_ff <= bus_in.wdata[WPD_BIT];
   end

   // per pair logic
   // every pair gets the same capture sequencer and output flops
   genvar g;
   generate
      for (g = 0; g < NUM_PAIRS; g++)
      begin : g_pair
         wire logic armed;  // arm only counts in dual edge mode
         assign armed = link_ff[g*PAIR_W+F_DEARM] & link_ff[g*PAIR_W+F_DEMODE];
         // upper capture only counts once the lower event has been seen
         assign upper_hit[g] = armed && cap_st_ff[g] == CAP_WAIT_UPPER && upper_evt_in[g];

         // dual edge sequence: lower event then upper event
         always_ff @(posedge clk_in or negedge resetn_in)
         begin
            if (!resetn_in)
               cap_st_ff[g] <= CAP_IDLE;
            else
            begin
               case (cap_st_ff[g])
                  CAP_IDLE:
                  begin
                     // wait for the lower channel event while armed
                     if (armed && lower_evt_in[g])
                        cap_st_ff[g] <= CAP_WAIT_UPPER;
                  end
                  CAP_WAIT_UPPER:
                  begin
                     // leave on the upper event or when software disarms the pair
                     if (!armed || upper_hit[g])
                        cap_st_ff[g] <= CAP_IDLE;
                  end
                  // unreachable encodings fall back to idle
                  default:
                     cap_st_ff[g] <= CAP_IDLE;
               endcase
            end
         end

         // capture pulse, done flag (set wins over read-clear) and outputs
         always_ff @(posedge clk_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               capture_out[g]     <= 1'b0;
               cap_done_ff[g]     <= 1'b0;
               lower_out_out[g]   <= 1'b0;
               upper_out_out[g]   <= 1'b0;
               combined_out[g]    <= 1'b0;
               fault_en_out[g]    <= 1'b0;
               sync_en_out[g]     <= 1'b0;
               deadtime_en_out[g] <= 1'b0;
               dual_mode_out[g]   <= 1'b0;
            end
            else
            begin
               // the pulse lags the upper event by one cycle
               capture_out[g] <= upper_hit[g];
               if (upper_hit[g])
                  cap_done_ff[g] <= 1'b1;
               else if (bus_in.rd && bus_in.addr == ADDR_PAIR_STAT)
                  cap_done_ff[g] <= 1'b0;
               // all outputs are flops, so the field outputs trail the register by one cycle
               lower_out_out[g]   <= lower_pwm_in[g];
               upper_out_out[g]   <= lower_pwm_in[g] ^ link_ff[g*PAIR_W+F_COMP];
               combined_out[g]    <= link_ff[g*PAIR_W+F_LINK];
               fault_en_out[g]    <= link_ff[g*PAIR_W+F_FAULT];
               sync_en_out[g]     <= link_ff[g*PAIR_W+F_SYNC];
               deadtime_en_out[g] <= link_ff[g*PAIR_W+F_DT];
               dual_mode_out[g]   <= link_ff[g*PAIR_W+F_DEMODE];
            end
         end
      end
   endgenerate

   // read data, valid the cycle after the strobe; unmapped reads zero
   // zero outside the read cycle keeps a bus mux in the parent simple
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         rdata_out <= 32'h0000_0000;
      else if (bus_in.rd)
      begin
         case (bus_in.addr)
            ADDR_LINK_CFG:  rdata_out <= link_ff;
            ADDR_MODE_CTRL: rdata_out <= 32'(wpd_ff) << WPD_BIT;
            ADDR_PAIR_STAT: rdata_out <= {28'h0000000, cap_done_ff};
            default:        rdata_out <= 32'h0000_0000;
         endcase
      end
      else
         rdata_out <= 32'h0000_0000;
   end

   // checks
   // pair four, pair six and all-pair checks; the same slice logic serves every pair
   property p_rsvd_zero;
      @(posedge clk_in) disable iff (!resetn_in) link_ff[23] == 1'b0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit 23 set");

   property p_protect;
      @(posedge clk_in) disable iff (!resetn_in)
         !wpd_ff |=> (link_ff & {4{PROT_MASK}}) == ($past(link_ff) & {4{PROT_MASK}});
   endproperty
   a_protect: assert property (p_protect) else $error("protected field changed");

   property p_unprot_write;
      @(posedge clk_in) disable iff (!resetn_in)
         (bus_in.wr && bus_in.addr == ADDR_LINK_CFG && !upper_hit[2])
            |=> link_ff[21] == $past(bus_in.wdata[21]);
   endproperty
   a_unprot_write: assert property (p_unprot_write) else $error("sync enable not written");

   property p_comb6;
      @(posedge clk_in) disable iff (!resetn_in) ##1 combined_out[3] == $past(link_ff[24]);
   endproperty
   a_comb6: assert property (p_comb6) else $error("pair six combine mismatch");

   property p_fault4;
      @(posedge clk_in) disable iff (!resetn_in) ##1 fault_en_out[2] == $past(link_ff[22]);
   endproperty
   a_fault4: assert property (p_fault4) else $error("fault enable mismatch");

   property p_dt4;
      @(posedge clk_in) disable iff (!resetn_in) ##1 deadtime_en_out[2] == $past(link_ff[20]);
   endproperty
   a_dt4: assert property (p_dt4) else $error("deadtime enable mismatch");

   property p_arm_gate;
      @(posedge clk_in) disable iff (!resetn_in) !link_ff[18] |=> !capture_out[2];
   endproperty
   a_arm_gate: assert property (p_arm_gate) else $error("capture without mode");

   property p_oneshot;
      @(posedge clk_in) disable iff (!resetn_in) (upper_hit[2] && one_shot_in[2]) |=> !link_ff[19];
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("arm not cleared");

   property p_comp;
      @(posedge clk_in) disable iff (!resetn_in)
         ##1 upper_out_out[2] == ($past(lower_pwm_in[2]) ^ $past(link_ff[17]));
   endproperty
   a_comp: assert property (p_comp) else $error("complement output wrong");

   // sync enable output follows bit 21 one cycle later
   property p_sync4;
      @(posedge clk_in) disable iff (!resetn_in) ##1 sync_en_out[2] == $past(link_ff[21]);
   endproperty
   a_sync4: assert property (p_sync4) else $error("sync enable mismatch");

   // dual edge mode output follows bit 18 one cycle later
   property p_mode4;
      @(posedge clk_in) disable iff (!resetn_in) ##1 dual_mode_out[2] == $past(link_ff[18]);
   endproperty
   a_mode4: assert property (p_mode4) else $error("dual edge mode mismatch");

   // lower outputs are a plain one cycle copy of the pwm levels
   property p_lower_copy;
      @(posedge clk_in) disable iff (!resetn_in) ##1 lower_out_out == $past(lower_pwm_in);
   endproperty
   a_lower_copy: assert property (p_lower_copy) else $error("lower output not a copy");

   // a capture pulse lasts one cycle only
   property p_cap_pulse;
      @(posedge clk_in) disable iff (!resetn_in) capture_out[2] |=> !capture_out[2];
   endproperty
   a_cap_pulse: assert property (p_cap_pulse) else $error("capture pulse too long");

   // a capture pulse needs an upper event in the cycle before
   property p_cap_after_upper;
      @(posedge clk_in) disable iff (!resetn_in) capture_out[2] |-> $past(upper_evt_in[2]);
   endproperty
   a_cap_after_upper: assert property (p_cap_after_upper) else $error("capture without upper event");

   // a taken capture always leaves the done flag set
   property p_cap_done;
      @(posedge clk_in) disable iff (!resetn_in) upper_hit[2] |=> cap_done_ff[2];
   endproperty
   a_cap_done: assert property (p_cap_done) else $error("capture done not set");

   // continuous capture keeps the arm bit
   property p_cont_keep;
      @(posedge clk_in) disable iff (!resetn_in) (upper_hit[2] && !one_shot_in[2] && !bus_in.wr) |=> link_ff[19];
   endproperty
   a_cont_keep: assert property (p_cont_keep) else $error("arm cleared in continuous mode");

   // with protection disabled a protected field takes the written value
   property p_wpd_open;
      @(posedge clk_in) disable iff (!resetn_in)
         (wpd_ff && bus_in.wr && bus_in.addr == ADDR_LINK_CFG) |=> link_ff[22] == $past(bus_in.wdata[22]);
   endproperty
   a_wpd_open: assert property (p_wpd_open) else $error("protected field not written");

   // the reserved bit reads back as zero
   property p_rd_rsvd;
      @(posedge clk_in) disable iff (!resetn_in) (bus_in.rd && bus_in.addr == ADDR_LINK_CFG) |=> rdata_out[23] == 1'b0;
   endproperty
   a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved bit read as one");

   // combine outputs of all pairs follow their own slice
   property p_link_pairs;
      @(posedge clk_in) disable iff (!resetn_in)
         ##1 combined_out == $past({link_ff[24], link_ff[16], link_ff[8], link_ff[0]});
   endproperty
   a_link_pairs: assert property (p_link_pairs) else $error("pair combine outputs mismatch");

   // fault enable outputs of all pairs follow their own slice
   property p_fault_pairs;
      @(posedge clk_in) disable iff (!resetn_in)
         ##1 fault_en_out == $past({link_ff[30], link_ff[22], link_ff[14], link_ff[6]});
   endproperty
   a_fault_pairs: assert property (p_fault_pairs) else $error("pair fault outputs mismatch");
endmodule : tpl_link

/* File: verilog/tpl_pkg.sv */
// package for the timer channel pair linking block
package tpl_pkg;
   // register map (word addresses on the plain port)
   localparam logic [3:0]  ADDR_LINK_CFG   = 4'h0;  // channel_pair_link_config
   localparam logic [3:0]  ADDR_MODE_CTRL  = 4'h1;  // holds write_protect_disable
   localparam logic [3:0]  ADDR_PAIR_STAT  = 4'h2;  // per pair capture done status
   // per pair field offsets inside an 8-bit pair slice
   localparam int          F_LINK          = 0;     // combine
   localparam int          F_COMP          = 1;     // complement
   localparam int          F_DEMODE        = 2;     // dual edge mode enable
   localparam int          F_DEARM         = 3;     // dual edge arm
   localparam int          F_DT            = 4;     // deadtime enable
   localparam int          F_SYNC          = 5;     // value sync enable
   localparam int          F_FAULT         = 6;     // fault control enable
   localparam int          F_RSVD          = 7;     // reserved, reads zero
   localparam int          PAIR_W          = 8;     // bits per pair slice
   localparam int          NUM_PAIRS       = 4;     // pairs at channels 0,2,4,6
   localparam int          WPD_BIT         = 2;     // write_protect_disable in mode reg
   localparam logic [7:0]  PROT_MASK       = 8'h57; // fault, dt, demode, comp, link
   localparam logic [7:0]  RSVD_MASK       = 8'h80; // reserved bit of each slice
   localparam logic [31:0] LINK_RESET      = 32'h0000_0000;
   // register bus request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } tpl_bus_t;
   // capture state of one pair
   typedef enum logic [1:0] {CAP_IDLE, CAP_WAIT_UPPER} tpl_cap_t;
endpackage : tpl_pkg

/* File: tb/tpl_partner.sv */
// partner model: power-stage pwm source and capture input events
`timescale 1ns/100ps
module tpl_partner
(
   input  wire logic       clk_in,         // system clock
   input  wire logic       resetn_in,      // async reset, active low
   input  wire logic [3:0] fire_in,        // request one capture sequence
   input  wire logic       slow_in,        // late upper event
   output logic [3:0]      pwm_out,        // lower channel levels
   output logic [3:0]      lower_evt_out,  // lower channel event
   output logic [3:0]      upper_evt_out   // upper channel event
);
   logic [3:0] d1_ff;  // event delay taps
   logic [3:0] d2_ff;
   // pwm changes every cycle so a stale copy shows up
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pwm_out       <= 4'h0;
         lower_evt_out <= 4'h0;
         upper_evt_out <= 4'h0;
         d1_ff         <= 4'h0;
         d2_ff         <= 4'h0;
      end
      else
      begin
         pwm_out       <= pwm_out + 4'h5;
         lower_evt_out <= fire_in;
         d1_ff         <= lower_evt_out;
         d2_ff         <= d1_ff;
         // upper event comes one cycle after the lower one, three cycles after when slow
         upper_evt_out <= slow_in ? d2_ff : lower_evt_out;
      end
   end
endmodule : tpl_partner

/* File: tb/tpl_link_tb.sv */
// self-checking bench for the pair linking block
`timescale 1ns/100ps
module tpl_link_tb;
   import tpl_pkg::*;
   logic        clk_in     = 1'b0;
   logic        resetn_in  = 1'b0;
   tpl_bus_t    bus        = '0;
   logic [3:0]  fire       = 4'h0;
   logic [3:0]  one_shot   = 4'h0;
   logic        slow       = 1'b0;
   logic [3:0]  pwm, levt, uevt, lo, up, comb, flt, syn, dt, dm, cap;
   logic [31:0] rdat;
   logic [3:0]  pwm_d;  // pwm level as the design sampled it at the last edge
   int          n_mismatch = 0;
   int          n_tests    = 0;
   always #50 clk_in = ~clk_in;
   always @(posedge clk_in) pwm_d <= pwm;
   tpl_link uut (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus), .lower_pwm_in(pwm), .lower_evt_in(levt),
      .upper_evt_in(uevt), .one_shot_in(one_shot), .rdata_out(rdat), .lower_out_out(lo), .upper_out_out(up),
      .combined_out(comb), .fault_en_out(flt), .sync_en_out(syn), .deadtime_en_out(dt), .dual_mode_out(dm),
      .capture_out(cap));
   tpl_partner prt (.clk_in(clk_in), .resetn_in(resetn_in), .fire_in(fire), .slow_in(slow), .pwm_out(pwm),
      .lower_evt_out(levt), .upper_evt_out(uevt));
   task test_done;
      $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one-cycle write strobe
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clk_in);
      bus.wr    <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task rchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk_in);
      bus.rd   <= 1'b0;
      #1 chk(rdat, exp);
   endtask : rchk
   // field outputs lag the register by one cycle
   task fchk(input logic [19:0] exp);
      @(posedge clk_in);
      #1 chk({12'h0, comb, flt, syn, dt, dm}, {12'h0, exp});
   endtask : fchk
   task comp_chk(input logic [3:0] inv);
      repeat (4)
      begin
         @(posedge clk_in);
         #1 chk({28'h0, lo}, {28'h0, pwm_d});
         chk({28'h0, up}, {28'h0, pwm_d ^ inv});
      end
   endtask : comp_chk
   // one lower then upper event on pair 4, bounded watch for the pulse
   task cap_run(input logic sl, input logic exp_hit);
      logic hit;
      hit = 1'b0;
      @(posedge clk_in);
      fire <= 4'h4;
      slow <= sl;
      @(posedge clk_in);
      fire <= 4'h0;
      repeat (8)
      begin
         @(posedge clk_in);
         #1 if (cap === 4'h4) hit = 1'b1;
      end
      chk({31'h0, hit}, {31'h0, exp_hit});
   endtask : cap_run
   // guard against a hang
   initial
   begin
      repeat (5000) @(posedge clk_in);
      n_mismatch++;
      test_done();
   end
   initial
   begin
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      rchk(ADDR_LINK_CFG, LINK_RESET);
      fchk(20'h0);
      wr(ADDR_LINK_CFG, 32'hffff_ffff);
      rchk(ADDR_LINK_CFG, 32'h2828_2828);
      wr(ADDR_MODE_CTRL, 32'h0000_0004);
      wr(ADDR_LINK_CFG, 32'hffff_ffff);
      rchk(ADDR_LINK_CFG, 32'h7f7f_7f7f);
      fchk(20'hfffff);
      wr(ADDR_LINK_CFG, 32'h0100_0000);
      fchk(20'h80000);
      wr(ADDR_LINK_CFG, 32'h0040_0000);
      fchk(20'h04000);
      wr(ADDR_LINK_CFG, 32'h0020_0000);
      fchk(20'h00400);
      wr(ADDR_LINK_CFG, 32'h0010_0000);
      fchk(20'h00040);
      wr(ADDR_LINK_CFG, 32'h0004_0000);
      fchk(20'h00004);
      wr(ADDR_LINK_CFG, 32'h0002_0000);
      comp_chk(4'h4);
      wr(ADDR_LINK_CFG, 32'h0000_0000);
      comp_chk(4'h0);
      @(posedge clk_in);
      one_shot <= 4'h4;
      wr(ADDR_LINK_CFG, 32'h000c_0000);
      cap_run(1'b0, 1'b1);
      rchk(ADDR_LINK_CFG, 32'h0004_0000);
      rchk(ADDR_PAIR_STAT, 32'h0000_0004);
      rchk(ADDR_PAIR_STAT, 32'h0000_0000);
      @(posedge clk_in);
      one_shot <= 4'h0;
      wr(ADDR_LINK_CFG, 32'h000c_0000);
      cap_run(1'b1, 1'b1);
      rchk(ADDR_LINK_CFG, 32'h000c_0000);
      wr(ADDR_LINK_CFG, 32'h0008_0000);
      cap_run(1'b0, 1'b0);
      wr(ADDR_LINK_CFG, 32'h0004_0000);
      wr(ADDR_MODE_CTRL, 32'h0000_0000);
      wr(ADDR_LINK_CFG, 32'h0020_0000);
      rchk(ADDR_LINK_CFG, 32'h0024_0000);
      rchk(4'hf, 32'h0000_0000);
      test_done();
   end
endmodule : tpl_link_tb
